// *** logic/dsc_top.sv ***
// Purpose : deep sleep entry, pin hold, wake logging and wake reset sequencing
// Assumes : sleep_instr_i is one cycle per executed sleep; one clock cycle is one instruction cycle
// Notes   : rst_i stands for supply first applied; wake resets are generated here
//
// Implementation choice: strobed register access.
`timescale 1ns/1ps
`include "dsc_cfg.svh"
module dsc_top
  import dsc_pkg::*;
(
  input  wire logic                   ref_clk_i,           // 125 MHz clock
  input  wire logic                   rst_i,               // async reset, active high
  input  wire logic [`DSC_ADDR_W-1:0] addr_i,              // register byte address
  input  wire logic [`DSC_DATA_W-1:0] wr_data_i,           // write data
  input  wire logic                   wr_i,                // write strobe
  input  wire logic                   rd_i,                // read strobe
  output logic      [`DSC_DATA_W-1:0] rd_data_o,           // read data, cycle after rd_i
  input  wire logic [7:0]             config_word_low_i,   // configuration word
  input  wire logic                   sleep_instr_i,       // sleep instruction executed
  input  wire dsc_pins_type           pins_i,              // direction and level from core
  output logic      [`DSC_PIN_W-1:0]  pad_o,               // pad output level
  output logic      [`DSC_PIN_W-1:0]  pad_oe_o,            // pad output enable
  input  wire logic                   irc_tick_i,          // internal rc tick
  input  wire logic                   sosc_tick_i,         // secondary oscillator tick
  input  wire logic                   master_clear_i,      // master clear asserted
  input  wire logic                   alarm_i,             // calendar alarm
  input  wire logic                   ext_int_i,           // external interrupt pin event
  input  wire logic                   ulp_i,               // ultra-low-power wake event
  input  wire logic                   fault_i,             // internal node fault
  input  wire logic                   supply_below_arm_i,  // supply under brown-out arming level
  input  wire logic                   supply_below_trip_i, // supply under trip and power-on levels
  output logic                        core_reset_o,        // core held in reset
  output logic                        deep_sleep_o,        // regulator off
  output logic                        sleep_o,             // ordinary sleep
  output logic                        calendar_tick_o      // calendar clock tick
);

  dsc_state_type              state_q;
  logic                       deep_sleep_enable_q;
  logic [1:0]                 deep_sleep_enable_age_q;
  logic                       ulpen_q;
  logic                       alarm_dis_q;
  logic                       ulp_dis_q;
  logic                       bor_stat_q;
  logic                       hold_q;
  dsc_pins_type               snap_q;
  dsc_wake_type               wake_q;
  logic                       por_bit_q;
  logic                       exit_flag_q;
  logic [`DSC_DATA_W-1:0]     persist_q [2];
  logic [`DSC_POR_CNT_W-1:0]  por_cnt_q;
  dsc_wake_type               wake_raw;
  dsc_wake_type               wake_first;
  logic                       wdt_timeout;
  logic                       in_deep;
  logic                       enter_deep;
  logic                       wake_any;
  logic                       bor_trip;
  logic                       wr_hi;
  logic                       wr_lo;

  // keep the earliest source only; simultaneous events resolve by fixed order
  function automatic dsc_wake_type pick_first(input dsc_wake_type w);
    dsc_wake_type r;
    r = '0;
    if (w.fault)     r.fault = 1'b1;
    else if (w.master_clear_pin) r.master_clear_pin  = 1'b1;
    else if (w.wdt)  r.wdt   = 1'b1;
    else if (w.rtc)  r.rtc   = 1'b1;
    else if (w.ext)  r.ext   = 1'b1;
    else if (w.ulp)  r.ulp   = 1'b1;
    return r;
  endfunction

  // decodes and wake qualification
  assign in_deep    = (state_q == DSC_DEEP);
  assign enter_deep = (state_q == DSC_RUN) && sleep_instr_i && deep_sleep_enable_q;
  assign wr_hi      = wr_i && (addr_i == `DSC_OFF_CTRL_HI);
  assign wr_lo      = wr_i && (addr_i == `DSC_OFF_CTRL_LO);
  assign bor_trip   = config_word_low_i[`DSC_CFG_BOR_EN] && supply_below_trip_i;
  assign wake_raw.fault = fault_i;
  assign wake_raw.master_clear_pin  = master_clear_i;
  assign wake_raw.wdt   = wdt_timeout;
  assign wake_raw.rtc   = alarm_i && !alarm_dis_q;
  assign wake_raw.ext   = ext_int_i;
  assign wake_raw.ulp   = ulp_i && ulpen_q && !ulp_dis_q;
  assign wake_first = pick_first(wake_raw);
  assign wake_any   = |wake_raw;

  // calendar keeps its source through sleep; the controller only routes it
  assign calendar_tick_o = config_word_low_i[`DSC_CFG_CAL_SRC] ? sosc_tick_i : irc_tick_i;

  dsc_wdt u_wdt (
    .ref_clk_i   (ref_clk_i),
    .rst_i       (rst_i),
    .enable_i    (in_deep && config_word_low_i[`DSC_CFG_WDT_EN]),
    .clear_i     (enter_deep),
    .src_sel_i   (config_word_low_i[`DSC_CFG_WDT_SRC]),
    .irc_tick_i  (irc_tick_i),
    .sosc_tick_i (sosc_tick_i),
    .ps_sel_i    (config_word_low_i[`DSC_CFG_PS_MSB:`DSC_CFG_PS_LSB]),
    .timeout_o   (wdt_timeout)
  );

  // power state sequencing; every deep sleep exit passes through a reset
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_q   <= DSC_RUN;
      por_cnt_q <= '0;
    end else begin
      unique case (state_q)
        DSC_RUN: begin
          if (sleep_instr_i) begin
            state_q <= deep_sleep_enable_q ? DSC_DEEP : DSC_SLEEP;
          end
        end
        DSC_SLEEP: begin
          if (ext_int_i || master_clear_i) begin
            state_q <= DSC_RUN;
          end
        end
        DSC_DEEP: begin
          if (wake_any || bor_trip) begin
            state_q   <= DSC_POR;
            por_cnt_q <= `DSC_POR_CNT_W'(`DSC_POR_CYC - 1);
          end
        end
        DSC_POR: begin
          if (por_cnt_q == '0) begin
            state_q <= DSC_RUN;
          end else begin
            por_cnt_q <= por_cnt_q - `DSC_POR_CNT_W'(1);
          end
        end
      endcase
    end
  end

  assign core_reset_o = (state_q == DSC_POR);
  assign deep_sleep_o = in_deep;
  assign sleep_o      = (state_q == DSC_SLEEP);

  // deep sleep enable: short life guards against accidental entry
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      deep_sleep_enable_q     <= 1'b0;
      deep_sleep_enable_age_q <= '0;
    end else if (state_q == DSC_POR) begin
      deep_sleep_enable_q     <= 1'b0;
      deep_sleep_enable_age_q <= '0;
    end else if (wr_hi) begin
      deep_sleep_enable_q     <= wr_data_i[`DSC_HI_DEEP_SLEEP_ENABLE];
      deep_sleep_enable_age_q <= `DSC_DEEP_SLEEP_ENABLE_LIFE - 2'd1;
    end else if (deep_sleep_enable_q) begin
      if (deep_sleep_enable_age_q == '0) begin
        deep_sleep_enable_q <= 1'b0;
      end else begin
        deep_sleep_enable_age_q <= deep_sleep_enable_age_q - 2'd1;
      end
    end
  end

  // ordinary control bits return to power-on values on a wake reset
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ulpen_q     <= 1'b0;
      alarm_dis_q <= 1'b0;
      ulp_dis_q   <= 1'b0;
    end else if (state_q == DSC_POR) begin
      ulpen_q     <= 1'b0;
      alarm_dis_q <= 1'b0;
      ulp_dis_q   <= 1'b0;
    end else begin
      if (wr_hi) begin
        ulpen_q     <= wr_data_i[`DSC_HI_ULPEN];
        alarm_dis_q <= wr_data_i[`DSC_HI_ALARM_DIS];
      end
      if (wr_lo) begin
        ulp_dis_q <= wr_data_i[`DSC_LO_ULP_DIS];
      end
    end
  end

  // brown-out event status: armed but not tripped while asleep
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      bor_stat_q <= 1'b0;
    end else if (enter_deep) begin
      bor_stat_q <= 1'b0;
    end else if (in_deep && config_word_low_i[`DSC_CFG_BOR_EN] && supply_below_arm_i && !supply_below_trip_i) begin
      bor_stat_q <= 1'b1;
    end else if (wr_lo && !wr_data_i[`DSC_LO_BOR_STAT]) begin
      bor_stat_q <= 1'b0;
    end
  end

  // pin hold: snapshot at entry, released by software, master clear or trip
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      hold_q <= 1'b0;
      snap_q <= '0;
    end else if (enter_deep) begin
      hold_q <= 1'b1;
      snap_q <= pins_i;
    end else if (in_deep && (bor_trip || (master_clear_i && wake_first.master_clear_pin))) begin
      hold_q <= 1'b0;
    end else if (wr_lo && !wr_data_i[`DSC_LO_RELEASE] && !in_deep) begin
      hold_q <= 1'b0;
    end
  end

  // pads follow the snapshot while held, else the live core registers
  always_comb begin
    if (hold_q) begin
      pad_oe_o = ~snap_q.dir;
      pad_o    = snap_q.lvl;
    end else begin
      pad_oe_o = ~pins_i.dir;
      pad_o    = pins_i.lvl;
    end
  end

  // wake log: cleared at entry, set only in deep sleep, first source only
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      wake_q    <= '0;
      por_bit_q <= 1'(`DSC_WAKE_LO_RST);
    end else if (enter_deep) begin
      wake_q    <= '0;
      por_bit_q <= 1'b0;
    end else if (in_deep && bor_trip) begin
      por_bit_q <= 1'b1;
    end else if (in_deep && wake_any) begin
      wake_q <= wake_first;
    end else begin
      if (wr_i && addr_i == `DSC_OFF_WAKE_LO) begin
        wake_q.fault <= wr_data_i[7];
        wake_q.ulp   <= wr_data_i[5];
        wake_q.wdt   <= wr_data_i[4];
        wake_q.rtc   <= wr_data_i[3];
        wake_q.master_clear_pin  <= wr_data_i[2];
        por_bit_q    <= wr_data_i[0];
      end
      if (wr_i && addr_i == `DSC_OFF_WAKE_HI) begin
        wake_q.ext <= wr_data_i[0];
      end
    end
  end

  // exit flag: hardware set wins over a software clear in the same cycle
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      exit_flag_q <= 1'b0;
    end else if (in_deep && (wake_any || bor_trip)) begin
      exit_flag_q <= 1'b1;
    end else if (wr_i && addr_i == `DSC_OFF_EXIT && !wr_data_i[0]) begin
      exit_flag_q <= 1'b0;
    end
  end

  // persistent bytes survive wake resets; only a brown-out trip loses them
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      persist_q[0] <= '0;
      persist_q[1] <= '0;
    end else if (in_deep && bor_trip) begin
      persist_q[0] <= '0;
      persist_q[1] <= '0;
    end else if (wr_i && addr_i == `DSC_OFF_PERSIST0) begin
      persist_q[0] <= wr_data_i;
    end else if (wr_i && addr_i == `DSC_OFF_PERSIST1) begin
      persist_q[1] <= wr_data_i;
    end
  end

  // read port: data one cycle after the strobe, zero otherwise
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rd_data_o <= '0;
    end else if (rd_i) begin
      unique case (addr_i)
        `DSC_OFF_WAKE_LO:  rd_data_o <= {wake_q.fault, 1'b0, wake_q.ulp, wake_q.wdt, wake_q.rtc,
                                         wake_q.master_clear_pin, 1'b0, por_bit_q};
        `DSC_OFF_WAKE_HI:  rd_data_o <= {7'h00, wake_q.ext};
        `DSC_OFF_CTRL_LO:  rd_data_o <= {5'h00, ulp_dis_q, bor_stat_q, hold_q};
        `DSC_OFF_CTRL_HI:  rd_data_o <= {deep_sleep_enable_q, 4'h0, 1'b0, ulpen_q, alarm_dis_q};
        `DSC_OFF_PERSIST0: rd_data_o <= persist_q[0];
        `DSC_OFF_PERSIST1: rd_data_o <= persist_q[1];
        `DSC_OFF_EXIT:     rd_data_o <= {7'h00, exit_flag_q};
        default:           rd_data_o <= 8'h00;
      endcase
    end else begin
      rd_data_o <= '0;
    end
  end

  // checks
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);

  sequence s_deep_entry;
    (state_q == DSC_RUN) && sleep_instr_i && deep_sleep_enable_q;
  endsequence

  sequence s_deep_wake;
    in_deep && wake_any && !bor_trip;
  endsequence

  AST_ENTRY_DEEP: assert property (s_deep_entry |=> state_q == DSC_DEEP)
    else $error("deep sleep not entered");
  AST_ENTRY_SLEEP: assert property ((state_q == DSC_RUN) && sleep_instr_i && !deep_sleep_enable_q |=> state_q == DSC_SLEEP)
    else $error("ordinary sleep not entered");
  AST_DEEP_SLEEP_ENABLE_LIFE: assert property ($rose(deep_sleep_enable_q) |-> deep_sleep_enable_q ##1 (deep_sleep_enable_q || state_q == DSC_DEEP)
                                  ##1 (!deep_sleep_enable_q || $past(wr_hi)))
    else $error("enable bit lifetime wrong");
  AST_HOLD_PADS: assert property (s_deep_entry |=> pad_oe_o == ~$past(pins_i.dir) && pad_o == $past(pins_i.lvl))
    else $error("pins not frozen at entry");
  AST_HOLD_AFTER: assert property (hold_q && !in_deep && !(wr_lo && !wr_data_i[`DSC_LO_RELEASE]) |=> hold_q)
    else $error("hold dropped without release");
  AST_BOR_TRIP: assert property (in_deep && bor_trip |=> !hold_q && persist_q[0] == '0 && por_bit_q)
    else $error("brown-out trip handling wrong");
  AST_MASTER_CLEAR_PIN_WAKE: assert property (s_deep_wake ##0 wake_first.master_clear_pin |=> !hold_q && $stable(persist_q[0]))
    else $error("master clear wake handling wrong");
  AST_WAKE_POR: assert property (s_deep_wake |=> core_reset_o ##(`DSC_POR_CYC) state_q == DSC_RUN)
    else $error("wake reset sequence wrong");
  AST_EXIT_FLAG: assert property (s_deep_wake |=> exit_flag_q)
    else $error("exit flag not set");
  AST_ENTRY_CLEAR: assert property (s_deep_entry |=> wake_q == '0 && !por_bit_q)
    else $error("wake log not cleared at entry");
  AST_NO_EARLY_LOG: assert property (!in_deep && !wr_i && !enter_deep |=> $stable(wake_q))
    else $error("wake logged outside deep sleep");
  AST_FIRST_ONLY: assert property ($onehot0(wake_q))
    else $error("more than one wake source logged");
  AST_ALARM_BLOCK: assert property (in_deep && alarm_dis_q && !ext_int_i && !ulp_i && !fault_i && !master_clear_i
                                    && !wdt_timeout && !bor_trip |=> in_deep)
    else $error("disabled alarm woke the device");

endmodule

// *** shared/dsc_cfg.svh ***
// Purpose : offsets, field positions, reset values and timing counts of the deep sleep controller
// Assumes : 8-bit register port, byte addresses as printed
// Notes   : definitions only
`ifndef DSC_CFG_SVH
`define DSC_CFG_SVH

`define DSC_ADDR_W        12
`define DSC_DATA_W        8
`define DSC_PIN_W         8

`define DSC_OFF_WAKE_LO   12'hF4A
`define DSC_OFF_WAKE_HI   12'hF4B
`define DSC_OFF_CTRL_LO   12'hF4C
`define DSC_OFF_CTRL_HI   12'hF4D
`define DSC_OFF_PERSIST0  12'hF4E
`define DSC_OFF_PERSIST1  12'hF4F
`define DSC_OFF_EXIT      12'hF50

`define DSC_CTRL_LO_RST   8'h00
`define DSC_CTRL_HI_RST   8'h00
`define DSC_WAKE_LO_RST   8'h01

`define DSC_HI_DEEP_SLEEP_ENABLE       7
`define DSC_HI_RESERVED   2
`define DSC_HI_ULPEN      1
`define DSC_HI_ALARM_DIS  0
`define DSC_LO_ULP_DIS    2
`define DSC_LO_BOR_STAT   1
`define DSC_LO_RELEASE    0

`define DSC_CFG_PS_MSB    7
`define DSC_CFG_PS_LSB    4
`define DSC_CFG_WDT_EN    3
`define DSC_CFG_BOR_EN    2
`define DSC_CFG_CAL_SRC   1
`define DSC_CFG_WDT_SRC   0

`define DSC_DEEP_SLEEP_ENABLE_LIFE     2'd2
`define DSC_CLK_PS        8000
`define DSC_POR_NS        1000
`define DSC_POR_CYC       ((`DSC_POR_NS * 1000 + `DSC_CLK_PS - 1) / `DSC_CLK_PS)
`define DSC_POR_CNT_W     8

`define DSC_WDT_CNT_W     37
`define DSC_WDT_BASE_LOG2 6
`define DSC_WDT_STEP_LOG2 2

`endif

// *** shared/dsc_pkg.sv ***
// Purpose : shared types of the deep sleep controller
// Assumes : dsc_cfg.svh supplies widths
// Notes   : state codes are one-hot
`include "dsc_cfg.svh"
package dsc_pkg;

  typedef enum logic [3:0] {
    DSC_RUN   = 4'h1,
    DSC_SLEEP = 4'h2,
    DSC_DEEP  = 4'h4,
    DSC_POR   = 4'h8
  } dsc_state_type;

  // direction (1 = input) and output level of the general pins
  typedef struct packed {
    logic [`DSC_PIN_W-1:0] dir;
    logic [`DSC_PIN_W-1:0] lvl;
  } dsc_pins_type;

  // logged wake sources, one bit each
  typedef struct packed {
    logic fault;
    logic ulp;
    logic wdt;
    logic rtc;
    logic master_clear_pin;
    logic ext;
  } dsc_wake_type;

endpackage

// *** logic/dsc_wdt.sv ***
// Purpose : deep sleep watchdog with four-bit postscaler
// Assumes : ticks are one-cycle enables synchronous to ref_clk_i
// Notes   : time-out after 2^(base + step*sel) ticks of the chosen source
`timescale 1ns/1ps
`include "dsc_cfg.svh"
module dsc_wdt
  import dsc_pkg::*;
(
  input  wire logic       ref_clk_i,    // system clock
  input  wire logic       rst_i,        // async reset, active high
  input  wire logic       enable_i,     // watchdog enabled and in deep sleep
  input  wire logic       clear_i,      // clear count, one-cycle pulse
  input  wire logic       src_sel_i,    // 1 = secondary oscillator, 0 = internal rc
  input  wire logic       irc_tick_i,   // internal rc tick
  input  wire logic       sosc_tick_i,  // secondary oscillator or clock input tick
  input  wire logic [3:0] ps_sel_i,     // postscale select
  output logic            timeout_o     // time-out, one-cycle pulse
);

  logic [`DSC_WDT_CNT_W-1:0] count_q;
  logic [`DSC_WDT_CNT_W-1:0] limit;
  logic                      tick;

  // wide counter instead of a prescaler chain keeps every select exact
  assign tick  = src_sel_i ? sosc_tick_i : irc_tick_i;
  assign limit = `DSC_WDT_CNT_W'(1) << (`DSC_WDT_BASE_LOG2 + (32'(ps_sel_i) << `DSC_WDT_STEP_LOG2) / 2);

  // count ticks; cleared on every entry
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      count_q   <= '0;
      timeout_o <= 1'b0;
    end else if (clear_i || !enable_i) begin
      count_q   <= '0;
      timeout_o <= 1'b0;
    end else begin
      timeout_o <= 1'b0;
      if (tick) begin
        if (count_q == limit - `DSC_WDT_CNT_W'(1)) begin
          count_q   <= '0;
          timeout_o <= 1'b1;
        end else begin
          count_q <= count_q + `DSC_WDT_CNT_W'(1);
        end
      end
    end
  end

endmodule

// *** testbench/dsc_wake_model.sv ***
// Purpose : wake sources and oscillator ticks on the far side of the deep sleep controller
// Assumes : one event sequence per go pulse, each line high for one cycle
// Notes   : ticks run free, so the calendar keeps counting through deep sleep
`timescale 1ns/1ps
module dsc_wake_model (
  input  wire logic       ref_clk_i, // system clock
  input  wire logic       go_i,      // start the selected event
  input  wire logic [2:0] sel_i,     // event kind
  output logic      [6:0] ev_o,      // {trip, arm, master_clear_pin, fault, ulp, ext, alarm}
  output logic            irc_o,     // internal rc tick, every second cycle
  output logic            sosc_o     // secondary tick, every third cycle
);
  logic [1:0] div_q;
  logic [1:0] chain_q;

  initial begin
    ev_o = 7'h00;
    irc_o = 1'b0;
    sosc_o = 1'b0;
    div_q = 2'h0;
    chain_q = 2'h0;
  end

  // free running ticks: the sources never pause for sleep
  always @(posedge ref_clk_i) begin
    irc_o <= ~irc_o;
    sosc_o <= (div_q == 2'h2);
    div_q <= (div_q == 2'h2) ? 2'h0 : div_q + 2'h1;
  end

  // kind 6 fires arm, ext, alarm in a row so that only the earliest may count
  always @(posedge ref_clk_i) begin
    ev_o <= 7'h00;
    if (go_i) begin
      case (sel_i)
        3'h5: ev_o <= 7'h40;
        3'h6: ev_o <= 7'h20;
        3'h7: ev_o <= 7'h00;
        default: ev_o <= 7'(7'h01 << sel_i);
      endcase
      chain_q <= (sel_i == 3'h6) ? 2'h2 : 2'h0;
    end else if (chain_q != 2'h0) begin
      ev_o <= (chain_q == 2'h2) ? 7'h02 : 7'h01;
      chain_q <= chain_q - 2'h1;
    end
  end
endmodule

// *** testbench/deep_sleep_controller_test.sv ***
// Purpose : self-checking bench for the deep sleep controller
// Assumes : one clock cycle is one instruction cycle; wake events come from the model
// Notes   : each wake kind runs a full entry, wake and release pass
`timescale 1ns/1ps
`include "dsc_cfg.svh"
module deep_sleep_controller_test;
  import dsc_pkg::*;
  logic         ref_clk_i, rst_i, wr_i, rd_i, sleep_i, go, irc, sosc;
  logic [2:0]   sel;
  logic [6:0]   ev;
  logic [11:0]  addr;
  logic [7:0]   wdat, cfg;
  dsc_pins_type pins;
  int           error_cnt = 0, comparisons = 0, cyc = 0;

  dsc_top dsc_top_inst (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .addr_i(addr), .wr_data_i(wdat), .wr_i(wr_i),
    .rd_i(rd_i), .rd_data_o(), .config_word_low_i(cfg), .sleep_instr_i(sleep_i), .pins_i(pins), .pad_o(),
    .pad_oe_o(), .irc_tick_i(irc), .sosc_tick_i(sosc), .master_clear_i(ev[4]), .alarm_i(ev[0]),
    .ext_int_i(ev[1]), .ulp_i(ev[2]), .fault_i(ev[3]), .supply_below_arm_i(ev[5]),
    .supply_below_trip_i(ev[6]), .core_reset_o(), .deep_sleep_o(), .sleep_o(), .calendar_tick_o());
  dsc_wake_model dsc_wake_model_inst (.ref_clk_i(ref_clk_i), .go_i(go), .sel_i(sel), .ev_o(ev),
    .irc_o(irc), .sosc_o(sosc));

  // clock and cycle count
  initial begin
    ref_clk_i = 1'b0;
    forever #4 ref_clk_i = ~ref_clk_i;
  end
  always @(posedge ref_clk_i) cyc <= cyc + 1;

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // one idle cycle after each strobe keeps a driver from assigning twice in a time step
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    addr <= a;
    wdat <= d;
    wr_i <= 1'b1;
    @(posedge ref_clk_i);
    wr_i <= 1'b0;
    @(posedge ref_clk_i);
  endtask

  task automatic chk_rd(input logic [11:0] a, input logic [7:0] e);
    addr <= a;
    rd_i <= 1'b1;
    @(posedge ref_clk_i);
    rd_i <= 1'b0;
    #1 check(dsc_top_inst.rd_data_o, e);
    @(posedge ref_clk_i);
  endtask

  task automatic fire(input logic [2:0] s);
    sel <= s;
    go <= 1'b1;
    @(posedge ref_clk_i);
    go <= 1'b0;
    @(posedge ref_clk_i);
  endtask

  // the sleep instruction must come within two cycles of the enable write; here it follows in the next cycle
  task automatic enter(input logic [7:0] hi);
    addr <= 12'hF4D;
    wdat <= (hi & 8'h03) | 8'h80;
    wr_i <= 1'b1;
    @(posedge ref_clk_i);
    wr_i <= 1'b0;
    // regulator sleep, idle select and calendar sync live outside this block; firmware readies them first
    sleep_i <= 1'b1;
    @(posedge ref_clk_i);
    sleep_i <= 1'b0;
    @(posedge ref_clk_i);
    #1 check(dsc_top_inst.deep_sleep_o, 1'b1);
  endtask

  // hi bit2 only asks for the ulp disable bit; enter masks it off the reserved bit
  task automatic run_wake(input logic [2:0] s, input logic [7:0] hi, cf, elo, ehi, ecl, ep);
    int n;
    int t0;
    int lim;
    // watchdog span: 2^(6+2*sel) ticks, irc every second cycle, secondary every third
    lim = (1 << (6 + 2 * int'(cf[7:4]))) * (cf[0] ? 3 : 2);
    cfg <= cf;
    wr(12'hF4E, 8'h5A);
    if (hi[2]) wr(12'hF4C, 8'h04);
    fire(3'h1); // ext while running must not be logged
    enter(hi);
    t0 = cyc;
    pins <= '{dir: 8'hFF, lvl: 8'h00};
    if (hi[0]) fire(3'h0);
    if (!hi[1] || hi[2]) fire(3'h2);
    repeat (6) @(posedge ref_clk_i);
    #1 check(dsc_top_inst.deep_sleep_o, 1'b1);
    check(dsc_top_inst.pad_oe_o, 8'hF0);
    check(dsc_top_inst.pad_o & 8'hF0, 8'hA0);
    fire(s);
    // look after the edge settles, so the first reset cycle is counted
    #1 n = 0;
    while (dsc_top_inst.core_reset_o !== 1'b1 && n < 1000) begin
      @(posedge ref_clk_i);
      #1 n++;
    end
    if (s == 3'h7) check(16'(cyc - t0 >= lim - 4 && cyc - t0 <= lim + 2), 16'h1);
    n = 0;
    do begin
      @(posedge ref_clk_i);
      #1 n++;
    end while (dsc_top_inst.core_reset_o === 1'b1 && n < 300);
    check(16'(n), 16'(`DSC_POR_CYC));
    check(dsc_top_inst.pad_oe_o, ecl[0] ? 8'hF0 : 8'h00);
    @(posedge ref_clk_i);
    chk_rd(12'hF4A, elo);
    chk_rd(12'hF4B, ehi);
    chk_rd(12'hF4C, ecl);
    chk_rd(12'hF4D, 8'h00);
    chk_rd(12'hF4E, ep);
    chk_rd(12'hF50, 8'h01);
    wr(12'hF4C, 8'h00);
    wr(12'hF50, 8'h00);
    check(dsc_top_inst.pad_oe_o, 8'h00);
    chk_rd(12'hF50, 8'h00);
    pins <= '{dir: 8'h0F, lvl: 8'hA5};
  endtask

  task automatic complete_run;
    $display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // a hang counts as a mismatch
  initial begin
    #100000;
    error_cnt++;
    complete_run();
  end

  // main sequence
  initial begin
    rst_i = 1'b1;
    wr_i = 1'b0;
    rd_i = 1'b0;
    sleep_i = 1'b0;
    go = 1'b0;
    sel = 3'h0;
    addr = 12'h000;
    wdat = 8'h00;
    cfg = 8'h00;
    pins = '{dir: 8'h0F, lvl: 8'hA5};
    repeat (12) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    @(posedge ref_clk_i);
    chk_rd(12'hF4A, 8'h01);
    chk_rd(12'hF4C, 8'h00);
    chk_rd(12'hF4D, 8'h00);
    chk_rd(12'hF00, 8'h00);
    wr(12'hF4D, 8'h03);
    chk_rd(12'hF4D, 8'h03);
    wr(12'hF4D, 8'h80);
    repeat (2) @(posedge ref_clk_i);
    chk_rd(12'hF4D, 8'h00);
    sleep_i <= 1'b1;
    @(posedge ref_clk_i);
    sleep_i <= 1'b0;
    @(posedge ref_clk_i);
    #1 check({dsc_top_inst.sleep_o, dsc_top_inst.deep_sleep_o}, 2'h2);
    fire(3'h1);
    #1 check(dsc_top_inst.sleep_o, 1'b0);
    repeat (3) begin
      @(posedge ref_clk_i);
      #1 check(dsc_top_inst.calendar_tick_o, irc);
    end
    cfg <= 8'h02;
    repeat (3) begin
      @(posedge ref_clk_i);
      #1 check(dsc_top_inst.calendar_tick_o, sosc);
    end
    @(posedge ref_clk_i);
    run_wake(3'h0, 8'h00, 8'h00, 8'h08, 8'h00, 8'h01, 8'h5A);
    run_wake(3'h1, 8'h07, 8'h00, 8'h00, 8'h01, 8'h01, 8'h5A);
    run_wake(3'h2, 8'h02, 8'h00, 8'h20, 8'h00, 8'h01, 8'h5A);
    run_wake(3'h3, 8'h00, 8'h00, 8'h80, 8'h00, 8'h01, 8'h5A);
    run_wake(3'h4, 8'h00, 8'h00, 8'h04, 8'h00, 8'h00, 8'h5A);
    run_wake(3'h6, 8'h00, 8'h04, 8'h00, 8'h01, 8'h03, 8'h5A);
    run_wake(3'h7, 8'h00, 8'h08, 8'h10, 8'h00, 8'h01, 8'h5A);
    run_wake(3'h7, 8'h00, 8'h19, 8'h10, 8'h00, 8'h01, 8'h5A);
    run_wake(3'h5, 8'h00, 8'h04, 8'h01, 8'h00, 8'h00, 8'h00);
    complete_run();
  end
endmodule
